// [verilog/mmd_decoder.sv]
// Top: address decoder, register windows, AXI4-Lite slave, stop control
`default_nettype none
module mmd_decoder #(
  parameter int REC_CYCLES = mmd_pkg::REC_STOP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  // CPU / bus-master address port, same clock
  input wire logic cpuReq,
  input wire logic [31:0] cpuAddr,
  output mmd_pkg::mmd_region_t region_r,
  output logic regionValid_r,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [mmd_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [mmd_pkg::AXI_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Register contents for the peripherals behind them
  output logic [8*mmd_pkg::NUM_SLOTS-1:0] sfrBytes,
  // Power control
  input wire logic wakeIrq,
  input wire logic oscStable,
  output logic cpuClkEn,
  output logic oscEnable,
  output logic recoverDone
);
  import mmd_pkg::*;

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------

  // Register index to slot number, SLOT_NONE for reserved locations
  function automatic logic [4:0] sfrSlot(input logic [9:0] idx);
    logic [4:0] slot;
    slot = SLOT_NONE;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (SLOT_IDX[i] == idx) begin
        slot = 5'(i);
      end
    end
    return slot;
  endfunction : sfrSlot

  // Bus byte address to slot; only word-aligned low-window words hit
  function automatic logic [4:0] busSlot(input logic [AXI_AW-1:0] a);
    logic [4:0] slot;
    slot = SLOT_NONE;
    if (a[AXI_AW-1] == 1'b0 && a[1:0] == 2'b00) begin
      slot = sfrSlot(a[11:2]);
    end
    return slot;
  endfunction : busSlot

  // ----------------------------------------------------------------------
  // CPU address decode
  // ----------------------------------------------------------------------
  mmd_region_t regionNxt; // Combinational decode of cpuAddr

  // Whole 32-bit space; every address lands in exactly one of rom, ram, sfrLow, sfrHigh, unmapped
  always_comb begin
    regionNxt = '0;
    regionNxt.rom = (cpuAddr >= ROM_BASE);
    regionNxt.vector = (cpuAddr >= VEC_BASE);
    // Data and stack traffic share one RAM decode
    regionNxt.ram = (cpuAddr >= RAM_BASE) && (cpuAddr <= RAM_LAST);
    regionNxt.sfrLow = (cpuAddr <= SFR_LO_LAST);
    regionNxt.sfrHigh = (cpuAddr >= SFR_HI_BASE) &&
                        (cpuAddr <= SFR_HI_LAST);
    regionNxt.sfrImpl = regionNxt.sfrLow &&
                        (sfrSlot(cpuAddr[9:0]) != SLOT_NONE);
    regionNxt.unmapped = !(regionNxt.rom || regionNxt.ram ||
                           regionNxt.sfrLow || regionNxt.sfrHigh);
  end

  // Result registered one cycle after the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      region_r <= '0;
      regionValid_r <= 1'b0;
    end else begin
      regionValid_r <= cpuReq;
      if (cpuReq) begin
        region_r <= regionNxt;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------------
  logic awHeld_r; // Write address taken, waiting for data
  logic wHeld_r; // Write data taken, waiting for address
  logic [AXI_AW-1:0] awAddr_r; // Captured write address
  logic [31:0] wData_r; // Captured write data
  logic [3:0] wStrb_r; // Captured byte strobes
  logic doWrite; // Both halves present, response slot free
  logic awHeldNxt;
  logic wHeldNxt;
  logic bValidNxt;
  logic [4:0] wrSlot; // Target register of this write
  logic wrCtrl; // Write hits the control word

  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign wrSlot = busSlot(awAddr_r);
  assign wrCtrl = (awAddr_r == CTRL_ADDR);

  // Address and data may arrive in either order
  always_comb begin
    awHeldNxt = awHeld_r ? !doWrite : (s_axi_awvalid && s_axi_awready);
    wHeldNxt = wHeld_r ? !doWrite : (s_axi_wvalid && s_axi_wready);
    bValidNxt = doWrite || (s_axi_bvalid && !s_axi_bready);
  end

  // Capture each half on its own handshake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
    end else begin
      awHeld_r <= awHeldNxt;
      wHeld_r <= wHeldNxt;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
    end
  end

  // Readies fall while a half is held or a response waits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeldNxt && !bValidNxt;
      s_axi_wready <= !wHeldNxt && !bValidNxt;
      s_axi_bvalid <= bValidNxt;
      if (doWrite) begin
        // Reserved locations answer an error and store nothing
        s_axi_bresp <= (wrSlot != SLOT_NONE || wrCtrl ||
                        awAddr_r == STAT_ADDR) ?
                       RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register bytes
  // ----------------------------------------------------------------------
  logic [7:0] sfrReg [NUM_SLOTS]; // Implemented register bytes
  logic [7:0] sfrRegFree [NUM_SLOTS]; // Storage of unreset bits

  // Defined bits reset, undefined bits keep no reset at all, so they
  // come up unspecified as the part would; only lane 0 is stored
  for (genvar g = 0; g < NUM_SLOTS; g++) begin : gSlot
    logic wrHit; // This byte is written now
    assign wrHit = doWrite && wStrb_r[0] && (wrSlot == 5'(g));

    // Bits with a reset value
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        sfrReg[g] <= SLOT_RST_VAL & SLOT_DEF_MASK[g] ;
      end else if (wrHit) begin
        sfrReg[g] <= SLOT_DEF_MASK[g] & wData_r[7:0];
      end
    end
  end

  // Undefined upper bits, shadowed without reset; masked when read
  for (genvar g = 0; g < NUM_SLOTS; g++) begin : gFree
    always_ff @(posedge clk) begin
      if (gSlot[g].wrHit) begin
        sfrRegFree[g] <= wData_r[7:0];
      end
    end
  end

  // Flattened copy for the peripherals
  for (genvar g = 0; g < NUM_SLOTS; g++) begin : gOut
    assign sfrBytes[8*g +: 8] =
      sfrReg[g] | (sfrRegFree[g] & ~SLOT_DEF_MASK[g]);
  end

  // ----------------------------------------------------------------------
  // Control word and stop request
  // ----------------------------------------------------------------------
  logic stopReq_r; // One-cycle stop entry request

  // Writing the stop bit is a command, it reads back as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stopReq_r <= 1'b0;
    end else begin
      stopReq_r <= doWrite && wrCtrl && wStrb_r[0] &&
                   wData_r[CTRL_STOP_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] wakeSync_r; // Wake interrupt, bit 0 is the first stage
  logic [1:0] oscSync_r; // Oscillator stable, bit 0 is the first stage

  // Two flops each; only bit 1 is read by logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wakeSync_r <= 2'b00;
      oscSync_r <= 2'b00;
    end else begin
      wakeSync_r <= {wakeSync_r[0], wakeIrq};
      oscSync_r <= {oscSync_r[0], oscStable};
    end
  end

  // ----------------------------------------------------------------------
  // Stop recovery
  // ----------------------------------------------------------------------
  mmd_pwr_state_t pwrState; // Sequencer state for status reads

  mmd_stop_recovery #(
    .REC_CYCLES(REC_CYCLES)
  ) uRecovery (
    .clk(clk),
    .rst(rst),
    .stopReq(stopReq_r),
    .wakeSync(wakeSync_r[1]),
    .cpuClkEn_r(cpuClkEn),
    .oscEnable_r(oscEnable),
    .recoverDone_r(recoverDone),
    .state_r(pwrState)
  );

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  logic arHs; // Read address taken this cycle
  logic rValidNxt;
  logic [4:0] rdSlot; // Target register of this read
  logic [31:0] rdWord; // Word returned for the read
  logic rdOk; // Read hits something implemented

  assign arHs = s_axi_arvalid && s_axi_arready;
  assign rValidNxt = arHs || (s_axi_rvalid && !s_axi_rready);
  assign rdSlot = busSlot(s_axi_araddr);

  // Read mux; reserved words read zero with an error
  always_comb begin
    rdWord = 32'h00000000;
    rdOk = 1'b1;
    if (rdSlot != SLOT_NONE) begin
      rdWord[7:0] = sfrReg[rdSlot] |
                    (sfrRegFree[rdSlot] & ~SLOT_DEF_MASK[rdSlot]);
    end else if (s_axi_araddr == CTRL_ADDR) begin
      rdWord = 32'h00000000;
    end else if (s_axi_araddr == STAT_ADDR) begin
      rdWord[1:0] = pwrState;
      rdWord[2] = oscSync_r[1];
      rdWord[3] = cpuClkEn;
    end else begin
      rdOk = 1'b0;
    end
  end

  // One read in flight; answer lands one edge after the address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !rValidNxt;
      s_axi_rvalid <= rValidNxt;
      if (arHs) begin
        s_axi_rdata <= rdWord;
        s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

endmodule : mmd_decoder
`default_nettype wire

// [verilog/mmd_pkg.sv]
// Package: constants, types and register layout of the memory map decoder
//
// Notes on behaviour
// - Decode full 32-bit, four-gigabyte byte space.
// - ROM grows down from top, 512K.
// - Vector table is the top 36 bytes.
// - RAM grows up from 0x400 to 0xffff.
// - RAM takes data and stack accesses alike.
// - Two peripheral register windows are decoded.
// - Twelve interrupt enable bytes reset to zero.
// - Serial transmit controls reset low three bits.
// - Pull-up controls reset their defined bits.
// - CPU runs early; recovery ends by 225 us.
`default_nettype none
package mmd_pkg;

  // ----------------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------------
  localparam logic [31:0] ADDR_TOP = 32'hffffffff; // Last byte of space
  localparam logic [31:0] ROM_BASE = 32'hfff80000; // 512-Kbyte ROM start
  localparam logic [31:0] VEC_BASE = 32'hffffffdc; // Fixed vector table
  localparam logic [31:0] RAM_BASE = 32'h00000400; // RAM grows upward
  localparam logic [31:0] RAM_LAST = 32'h0000ffff; // 63-Kbyte RAM end
  localparam logic [31:0] SFR_LO_LAST = 32'h000003ff; // Low window end
  localparam logic [31:0] SFR_HI_BASE = 32'h00040000; // High window start
  localparam logic [31:0] SFR_HI_LAST = 32'h0004ffff; // High window end

  // ----------------------------------------------------------------------
  // Register slots: printed offsets kept as indices, byte address = 4 x
  // ----------------------------------------------------------------------
  localparam int NUM_SLOTS = 19;
  localparam logic [4:0] SLOT_NONE = 5'h1f; // No register at index
  localparam logic [9:0] SLOT_IDX [NUM_SLOTS] = '{
    10'h0b0, 10'h0b1, 10'h0b2, 10'h0b3, 10'h0b4, 10'h0b5, 10'h0b6,
    10'h0b7, 10'h0b8, 10'h0b9, 10'h0ba, 10'h0bb, // Interrupt enables
    10'h0dd, 10'h0df,                            // Serial 7/8 tx control
    10'h3f0, 10'h3f1, 10'h3f2, 10'h3f3,          // Pull-up controls
    10'h3ff};                                    // Port control
  // Bits with a defined reset value; the rest are left unreset
  localparam logic [7:0] SLOT_DEF_MASK [NUM_SLOTS] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'h07, 8'h07,
    8'hff, 8'h0f, 8'hff, 8'h03,
    8'h01};
  localparam logic [7:0] SLOT_RST_VAL = 8'h00; // Defined bits reset low

  // ----------------------------------------------------------------------
  // Bus-side layout
  // ----------------------------------------------------------------------
  localparam int AXI_AW = 13; // Byte address width of the slave
  localparam logic [AXI_AW-1:0] CTRL_ADDR = 13'h1000; // Control word
  localparam logic [AXI_AW-1:0] STAT_ADDR = 13'h1004; // Status word
  localparam int CTRL_STOP_BIT = 0; // Write 1: enter stop mode
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Stop-mode recovery timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 200; // Core clock rate
  localparam int REC_STOP_US = 225; // Longest recovery time
  localparam int REC_STOP_CYC = REC_STOP_US * CLK_MHZ; // Rounded down

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MMD_RUN = 2'b00,
    MMD_STOP = 2'b01,
    MMD_RECOVER = 2'b10
  } mmd_pwr_state_t;

  typedef struct packed {
    logic rom;      // Internal ROM
    logic vector;   // Fixed vector table (inside ROM)
    logic ram;      // Internal RAM
    logic sfrLow;   // Low register window
    logic sfrHigh;  // High register window
    logic sfrImpl;  // Hit an implemented register here
    logic unmapped; // None of the above
  } mmd_region_t;

endpackage : mmd_pkg
`default_nettype wire

// [verilog/mmd_stop_recovery.sv]
// Stop-mode entry and recovery sequencer
`default_nettype none
module mmd_stop_recovery #(
  parameter int REC_CYCLES = mmd_pkg::REC_STOP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic stopReq,
  input wire logic wakeSync,
  output logic cpuClkEn_r,
  output logic oscEnable_r,
  output logic recoverDone_r,
  output mmd_pkg::mmd_pwr_state_t state_r
);
  import mmd_pkg::*;

  // ----------------------------------------------------------------------
  // State and counter
  // ----------------------------------------------------------------------
  logic [15:0] count_r; // Cycles spent recovering
  logic countEnd; // Recovery budget used up

  assign countEnd = (count_r == 16'(REC_CYCLES - 1));

  // Power state: the wake goes straight to recovery with the CPU running
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= MMD_RUN;
    end else begin
      case (state_r)
        MMD_RUN: begin
          if (stopReq) begin
            state_r <= MMD_STOP;
          end
        end
        MMD_STOP: begin
          if (wakeSync) begin
            state_r <= MMD_RECOVER;
          end
        end
        MMD_RECOVER: begin
          if (countEnd) begin
            state_r <= MMD_RUN;
          end
        end
        default: begin
          state_r <= MMD_RUN;
        end
      endcase
    end
  end

  // Recovery counter, cleared outside recovery
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= 16'h0000;
    end else if (state_r == MMD_RECOVER && !countEnd) begin
      count_r <= count_r + 16'h0001;
    end else begin
      count_r <= 16'h0000;
    end
  end

  // CPU clock restarts on wake, not on oscillator stability
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpuClkEn_r <= 1'b1;
      oscEnable_r <= 1'b1;
      recoverDone_r <= 1'b0;
    end else begin
      if (state_r == MMD_RUN && stopReq) begin
        cpuClkEn_r <= 1'b0;
        oscEnable_r <= 1'b0;
      end else if (state_r == MMD_STOP && wakeSync) begin
        cpuClkEn_r <= 1'b1;
        oscEnable_r <= 1'b1;
      end
      recoverDone_r <= (state_r == MMD_RECOVER) && countEnd;
    end
  end

endmodule : mmd_stop_recovery
`default_nettype wire

// [testbench/mmd_decoder_properties.sv]
// Checker for decode, register bus and stop recovery
`default_nettype none
module mmd_decoder_properties #(
  parameter int REC_CYCLES = mmd_pkg::REC_STOP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cpuReq,
  input wire logic [31:0] cpuAddr,
  input wire mmd_pkg::mmd_region_t region_r,
  input wire logic regionValid_r,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic wakeIrq,
  input wire logic cpuClkEn,
  input wire logic oscEnable,
  input wire logic recoverDone
);
  import mmd_pkg::*;
  logic [15:0] recCnt_r; // Cycles since the CPU clock came back

  // ----------------------------------------------------------------------
  // Recovery counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      recCnt_r <= 16'h0;
    end else if (!cpuClkEn) begin
      recCnt_r <= 16'h0; // Held at zero while stopped
    end else if (recCnt_r != 16'hffff) begin
      recCnt_r <= recCnt_r + 16'h1; // Saturates, never wraps
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking dcb @(posedge clk); endclocking
  default disable iff (rst);

  a_valid_follows: assert property (cpuReq |=> regionValid_r)
    else $error("region valid missing after a request");
  a_valid_needs_req: assert property (!cpuReq |=> !regionValid_r)
    else $error("region valid without a request");
  a_region_stands: assert property (!cpuReq |=> $stable(region_r))
    else $error("region changed without a request");
  a_rom_top: assert property (cpuReq && cpuAddr >= ROM_BASE
    |=> region_r.rom && !region_r.unmapped) else $error("ROM not decoded");
  a_vector_top: assert property (cpuReq
    |=> region_r.vector == ($past(cpuAddr) >= VEC_BASE))
    else $error("vector table decode wrong");
  a_ram_up: assert property (cpuReq
    |=> region_r.ram == ($past(cpuAddr) >= RAM_BASE
    && $past(cpuAddr) <= RAM_LAST)) else $error("RAM decode wrong");
  a_sfr_windows: assert property (cpuReq
    |=> region_r.sfrLow == ($past(cpuAddr) <= SFR_LO_LAST)
    && region_r.sfrHigh == ($past(cpuAddr) >= SFR_HI_BASE
    && $past(cpuAddr) <= SFR_HI_LAST)) else $error("SFR window wrong");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_clock_resumes: assert property (!cpuClkEn && wakeIrq
    |-> ##[1:4] cpuClkEn) else $error("CPU clock not resumed after wake");
  a_osc_with_cpu: assert property ($rose(cpuClkEn) |-> oscEnable)
    else $error("oscillator off while CPU clock resumes");
  a_recover_bound: assert property (recoverDone
    |-> recCnt_r <= REC_CYCLES + 1) else $error("recovery too long");
endmodule : mmd_decoder_properties

bind mmd_decoder mmd_decoder_properties #(.REC_CYCLES(REC_CYCLES)) props_i (
  .clk(clk), .rst(rst), .cpuReq(cpuReq), .cpuAddr(cpuAddr),
  .region_r(region_r), .regionValid_r(regionValid_r),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .wakeIrq(wakeIrq), .cpuClkEn(cpuClkEn), .oscEnable(oscEnable),
  .recoverDone(recoverDone));
`default_nettype wire

// [testbench/mmd_cpu_master.sv]
// CPU-side address source feeding the decoder
`default_nettype none
module mmd_cpu_master (
  input wire logic clk,
  output logic cpuReq,
  output logic [31:0] cpuAddr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cpuReq = 1'b0;
    cpuAddr = 32'h0;
  end

  // One request per edge, back to back
  // Reserved places only when a scenario asks
  // Single-chip use, so no internal-use regions are avoided
  task automatic issue(input logic [31:0] addr);
    @(posedge clk);
    cpuReq <= 1'b1;
    cpuAddr <= addr;
  endtask : issue

  // Released lines show garbage
  task automatic release_bus();
    @(posedge clk);
    cpuReq <= 1'b0;
    cpuAddr <= ~cpuAddr;
  endtask : release_bus
endmodule : mmd_cpu_master
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the memory map decoder
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mmd_pkg::*;
  localparam int REC = 8; // Short recovery for simulation
  localparam logic [31:0] ADDRS [16] = '{32'h0, 32'h3ff, 32'hb1, 32'hbc,
    32'h400, 32'hffff, 32'h10000, 32'h3ffff, 32'h40000, 32'h4ffff,
    32'h50000, 32'hfff7ffff, 32'hfff80000, 32'hffffffdb, 32'hffffffdc,
    32'hffffffff}; // Edges of every region
  logic clk, rst, wakeIrq, oscStable, cpuReq;
  logic [31:0] cpuAddr, wdata, rdata, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, regionValid_r;
  logic [12:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [8*NUM_SLOTS-1:0] sfrBytes;
  logic cpuClkEn, oscEnable, recoverDone;
  mmd_region_t region_r;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;

  mmd_decoder #(.REC_CYCLES(REC)) mmd_decoder_i (
    .clk(clk), .rst(rst), .cpuReq(cpuReq), .cpuAddr(cpuAddr),
    .region_r(region_r), .regionValid_r(regionValid_r),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .sfrBytes(sfrBytes), .wakeIrq(wakeIrq), .oscStable(oscStable),
    .cpuClkEn(cpuClkEn), .oscEnable(oscEnable), .recoverDone(recoverDone));
  mmd_cpu_master mmd_cpu_master_i (
    .clk(clk), .cpuReq(cpuReq), .cpuAddr(cpuAddr));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Watchdog: a hang counts as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  // Byte address is four times the register index
  function automatic logic [12:0] slot_addr(input int g);
    return {1'b0, SLOT_IDX[g], 2'b00};
  endfunction : slot_addr

  function automatic mmd_region_t region_of(input logic [31:0] a);
    mmd_region_t e;
    e = '0;
    e.rom = a >= ROM_BASE;
    e.vector = a >= VEC_BASE;
    e.ram = a >= RAM_BASE && a <= RAM_LAST;
    e.sfrLow = a <= SFR_LO_LAST;
    e.sfrHigh = a >= SFR_HI_BASE && a <= SFR_HI_LAST;
    for (int g = 0; g < NUM_SLOTS; g++) begin
      if (e.sfrLow && a[9:0] == SLOT_IDX[g]) e.sfrImpl = 1'b1;
    end
    e.unmapped = !(e.rom || e.ram || e.sfrLow || e.sfrHigh);
    return e;
  endfunction : region_of

  // Both halves offered together, each dropped once taken
  task automatic axi_write(input logic [12:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    bit aDone = 0, wDone = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    while (!(aDone && wDone)) begin
      @(posedge clk);
      if (!aDone && awready) begin
        aDone = 1;
        awvalid <= 1'b0;
      end
      if (!wDone && wready) begin
        wDone = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [12:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset_values();
    for (int g = 0; g < NUM_SLOTS; g++) begin
      axi_read(slot_addr(g), d, r);
      chk_val({30'h0, r}, {30'h0, RESP_OKAY});
      chk_val(d & {24'hffffff, SLOT_DEF_MASK[g]}, 32'h0);
    end
  endtask : test_reset_values

  // Upper lanes carry junk that must not land anywhere
  task automatic test_write_back();
    for (int g = 0; g < NUM_SLOTS; g++) begin
      axi_write(slot_addr(g), {24'hc3a5f0, 8'h5a ^ 8'(g)}, r);
      chk_val({30'h0, r}, {30'h0, RESP_OKAY});
      axi_read(slot_addr(g), d, r);
      chk_val(d, {24'h0, 8'h5a ^ 8'(g)});
      chk_val({24'h0, sfrBytes[8*g +: 8]}, {24'h0, 8'h5a ^ 8'(g)});
    end
  endtask : test_write_back

  task automatic test_reserved();
    axi_write(13'h02f0, 32'h000000ff, r);
    chk_val({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_read(13'h02f0, d, r);
    chk_val({d[29:0], r}, {30'h0, RESP_SLVERR});
    axi_read(13'h1ffc, d, r);
    chk_val({d[29:0], r}, {30'h0, RESP_SLVERR});
    axi_read(slot_addr(11), d, r);
    chk_val(d, {24'h0, 8'h5a ^ 8'd11});
  endtask : test_reserved

  // Back-to-back requests over every region edge
  task automatic test_decode();
    for (int i = 0; i <= 16; i++) begin
      if (i < 16) mmd_cpu_master_i.issue(ADDRS[i]);
      else mmd_cpu_master_i.release_bus();
      if (i > 0) begin
        #1;
        chk_val({25'h0, region_r}, {25'h0, region_of(ADDRS[i-1])});
        chk_val({31'h0, regionValid_r}, 32'h1);
      end
    end
    @(posedge clk);
    #1;
    chk_val({31'h0, regionValid_r}, 32'h0);
    chk_val({25'h0, region_r}, {25'h0, region_of(ADDRS[15])});
  endtask : test_decode

  // Stop, then wake before the oscillator settles
  task automatic test_stop();
    int n;
    axi_write(CTRL_ADDR, 32'h1, r);
    n = 0;
    while (cpuClkEn !== 1'b0 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk_val({31'h0, oscEnable}, 32'h0);
    axi_read(STAT_ADDR, d, r);
    chk_val(d & 32'hf, 32'h1);
    @(posedge clk);
    wakeIrq <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cpuClkEn !== 1'b1 && n < 10);
    chk_val(n, 4);
    chk_val({30'h0, oscStable, oscEnable}, 32'h1);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (recoverDone !== 1'b1 && n < 4 * REC);
    chk_val(32'(n <= REC + 1), 32'h1);
    wakeIrq <= 1'b0;
    oscStable <= 1'b1;
    @(posedge clk);
    chk_val({31'h0, recoverDone}, 32'h0);
    repeat (3) @(posedge clk);
    axi_read(STAT_ADDR, d, r);
    chk_val(d & 32'hf, 32'hc);
  endtask : test_stop

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    rst = 1'b1;
    {wakeIrq, oscStable, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    test_reset_values();
    test_write_back();
    test_reserved();
    test_decode();
    test_stop();
    conclude();
  end
endmodule : testbench
`default_nettype wire
